// ==== dcsc_map.vh ====
// constants of the channel source controller: register map, command word fields,
// opcodes, keyword codes, error codes, level limits and status bit positions.
// assumes a 32-bit word-addressed register bus with byte offsets below 8'hFF.
`ifndef DCSC_MAP_VH
`define DCSC_MAP_VH
// register byte offsets
`define DCSC_CMD_OFS 8'h00
`define DCSC_VALUE_OFS 8'h04
`define DCSC_RESULT_OFS 8'h08
`define DCSC_STATUS_OFS 8'h0C
`define DCSC_MODE_OFS 8'h10
`define DCSC_JUMPER_OFS 8'h14
// status groups at 0x20/0x30/0x40: +0 condition, +4 event, +8 enable
`define DCSC_GRP_BASE 4'h2
`define DCSC_GRP_COUNT 4'h3
`define DCSC_SUB_COND 2'h0
`define DCSC_SUB_EVENT 2'h1
`define DCSC_SUB_ENABLE 2'h2
// command word fields
`define DCSC_OP_LSB 0
`define DCSC_OP_MSB 3
`define DCSC_CH_LSB 8
`define DCSC_CH_MSB 12
`define DCSC_KW_LSB 16
`define DCSC_KW_MSB 17
// opcodes
`define DCSC_OP_CI_SET 4'h1
`define DCSC_OP_CI_QRY 4'h2
`define DCSC_OP_CT_SET 4'h3
`define DCSC_OP_CT_QRY 4'h4
`define DCSC_OP_MODE_SET 4'h5
`define DCSC_OP_MODE_QRY 4'h6
`define DCSC_OP_VI_SET 4'h7
`define DCSC_OP_VI_QRY 4'h8
`define DCSC_OP_VT_SET 4'h9
`define DCSC_OP_VT_QRY 4'hA
`define DCSC_OP_RELAY_SET 4'hB
`define DCSC_OP_RELAY_QRY 4'hC
`define DCSC_OP_INIT 4'hD
`define DCSC_OP_TRIG 4'hE
// keyword codes
`define DCSC_KW_VAL 2'h0
`define DCSC_KW_MIN 2'h1
`define DCSC_KW_MAX 2'h2
`define DCSC_KW_DEF 2'h3
// error codes
`define DCSC_ERR_NONE 4'h0
`define DCSC_ERR_CH 4'h1
`define DCSC_ERR_MODE 4'h2
`define DCSC_ERR_ARMED 4'h3
`define DCSC_ERR_JUMPER 4'h4
`define DCSC_ERR_RANGE 4'h5
`define DCSC_ERR_OP 4'h6
// float32 levels and reply texts
`define DCSC_V_MAX 32'h41800000
`define DCSC_V_MIN 32'hC1800000
`define DCSC_I_MAX 32'h3CA3D70A
`define DCSC_I_MIN 32'hBCA3D70A
`define DCSC_LEVEL_RST 32'h00000000
`define DCSC_TXT_CURR 32'h43555252
`define DCSC_TXT_VOLT 32'h564F4C54
// status word and event bits
`define DCSC_ST_ERR_BIT 0
`define DCSC_ST_ARMED_BIT 1
`define DCSC_ST_CODE_LSB 4
`define DCSC_ST_CODE_MSB 7
`define DCSC_ST_SUM_LSB 8
`define DCSC_ST_SUM_MSB 10
`define DCSC_QUES_TRIG_IGN_BIT 9
`define DCSC_ESR_EXEC_BIT 4
`endif

// ==== dcsc_chan.v ====
// one output channel: mode, stored levels, pending triggered level, relay.
// assumes the controller sends at most one command strobe per cycle.
`timescale 1ns/1ns
`default_nettype none
`include "dcsc_map.vh"
module dcsc_chan (
  input wire clk,
  input wire reset_n,
  input wire load_strap,
  input wire prog_sel,
  input wire vi_cur,
  input wire set_mode,
  input wire mode_in,
  input wire set_imm,
  input wire set_trig,
  input wire [31:0] level_in,
  input wire fire,
  input wire set_relay,
  input wire relay_in,
  output reg mode_cur,
  output reg [31:0] imm_level,
  output reg [31:0] last_level,
  output reg relay,
  output reg [31:0] dac_level
);

reg [31:0] pend;
reg pend_ok;
reg [31:0] out_level;
reg next_mode;
reg [31:0] next_imm;
reg [31:0] next_last;
reg [31:0] next_pend;
reg next_pend_ok;
reg [31:0] next_out;
reg next_relay;

// next state, later strobes take precedence
always @* begin
  next_mode = mode_cur;
  next_imm = imm_level;
  next_last = last_level;
  next_pend = pend;
  next_pend_ok = pend_ok;
  next_out = out_level;
  next_relay = relay;
  if (fire && pend_ok) begin
    next_out = pend;
    next_pend_ok = 1'b0;
  end
  if (load_strap && !prog_sel) begin
    next_mode = vi_cur;
  end
  if (set_mode) begin
    next_mode = mode_in;
    next_relay = 1'b0;
    next_imm = `DCSC_LEVEL_RST;
    next_last = `DCSC_LEVEL_RST;
    next_out = `DCSC_LEVEL_RST;
    next_pend_ok = 1'b0;
  end
  if (set_imm) begin
    next_imm = level_in;
    next_last = level_in;
    next_out = level_in;
  end
  if (set_trig) begin
    next_pend = level_in;
    next_pend_ok = 1'b1;
    next_last = level_in;
  end
  if (set_relay) begin
    next_relay = relay_in;
  end
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    mode_cur <= 1'b0;
    imm_level <= `DCSC_LEVEL_RST;
    last_level <= `DCSC_LEVEL_RST;
    pend <= `DCSC_LEVEL_RST;
    pend_ok <= 1'b0;
    out_level <= `DCSC_LEVEL_RST;
    relay <= 1'b0;
    dac_level <= `DCSC_LEVEL_RST;
  end else begin
    mode_cur <= next_mode;
    imm_level <= next_imm;
    last_level <= next_last;
    pend <= next_pend;
    pend_ok <= next_pend_ok;
    out_level <= next_out;
    relay <= next_relay;
    dac_level <= next_relay ? next_out : `DCSC_LEVEL_RST;
  end
end

endmodule // dcsc_chan
`default_nettype wire

// ==== dcsc_core.v ====
// command interpreter for the per-channel source control of a multichannel
// analog output module, with an AHB-Lite register slave.
// assumes single whole-word transfers and one clock; jumpers are static levels.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "dcsc_map.vh"
module dcsc_core #(
  parameter NUM_CH = 8
) (
  input wire clk,
  input wire reset_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [NUM_CH-1:0] prog_sel_jumper,
  input wire [NUM_CH-1:0] vi_cur_jumper,
  input wire trig_in,
  output wire [NUM_CH-1:0] ch_mode_cur,
  output wire [NUM_CH-1:0] relay_closed,
  output wire [NUM_CH*32-1:0] dac_level,
  output reg armed
);

localparam [5:0] NCH = NUM_CH[5:0];

reg wr_q, err_flag, init_done;
reg [7:0] addr_q;
reg [31:0] value_reg, result, next_result, kw_level, rd_mux, st_word;
reg [3:0] err_code, next_err;
reg do_mode, do_imm, do_trig, do_relay, do_init, do_swtrig, res_load;
wire [511:0] imm_bus, last_bus;
wire [15:0] mode16, relay16, prog16, vi16;
wire [47:0] ev_all, en_all;
wire [2:0] summ;

// zero-wait slave; only word transfers are issued, so hsize is not decoded
wire acc = hsel && hready && htrans[1];
wire rd_go = acc && !hwrite;
assign hreadyout = 1'b1;
assign hresp = 1'b0;

// address phase capture
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    wr_q <= 1'b0;
    addr_q <= 8'h00;
  end else begin
    wr_q <= acc && hwrite;
    if (acc) begin
      addr_q <= haddr[7:0];
    end
  end
end

// command fields are decoded straight from the data phase
wire cmd_go = wr_q && (addr_q == `DCSC_CMD_OFS);
wire [3:0] op = hwdata[`DCSC_OP_MSB:`DCSC_OP_LSB];
wire [4:0] idx = hwdata[`DCSC_CH_MSB:`DCSC_CH_LSB];
wire [1:0] kw = hwdata[`DCSC_KW_MSB:`DCSC_KW_LSB];
wire [4:0] ch = idx - 5'h01;
wire ch_ok = (idx != 5'h00) && ({1'b0, idx} <= NCH);
wire sel_cur = mode16[ch[3:0]];
wire sel_prog = prog16[ch[3:0]];
wire sel_relay = relay16[ch[3:0]];
wire [31:0] sel_imm = imm_bus[ch[3:0]*32 +: 32];
wire [31:0] sel_last = last_bus[ch[3:0]*32 +: 32];
wire op_cur = (op == `DCSC_OP_CI_SET) || (op == `DCSC_OP_CI_QRY) ||
              (op == `DCSC_OP_CT_SET) || (op == `DCSC_OP_CT_QRY);
wire op_trig = (op == `DCSC_OP_CT_SET) || (op == `DCSC_OP_VT_SET);
wire [31:0] lim_pos = op_cur ? `DCSC_I_MAX : `DCSC_V_MAX;
wire [31:0] lim_neg = op_cur ? `DCSC_I_MIN : `DCSC_V_MIN;
// magnitude compare on raw bits; NaN and infinity fail
wire range_ok = (kw != `DCSC_KW_VAL) || (value_reg[30:0] <= lim_pos[30:0]);
wire [31:0] level_arg = (kw == `DCSC_KW_VAL) ? value_reg : kw_level;

always @* begin
  case (kw)
    `DCSC_KW_MIN: kw_level = lim_neg;
    `DCSC_KW_MAX: kw_level = lim_pos;
    default: kw_level = `DCSC_LEVEL_RST;
  endcase
end

always @* begin
  next_err = `DCSC_ERR_NONE;
  do_mode = 1'b0;
  do_imm = 1'b0;
  do_trig = 1'b0;
  do_relay = 1'b0;
  do_init = 1'b0;
  do_swtrig = 1'b0;
  res_load = 1'b0;
  next_result = result;
  if (cmd_go) begin
    case (op)
      `DCSC_OP_CI_SET, `DCSC_OP_CT_SET, `DCSC_OP_VI_SET, `DCSC_OP_VT_SET: begin
        if (!ch_ok) begin
          next_err = `DCSC_ERR_CH;
        end else if (op_trig && armed) begin
          next_err = `DCSC_ERR_ARMED;
        end else if (sel_cur != op_cur) begin
          next_err = `DCSC_ERR_MODE;
        end else if (!range_ok) begin
          next_err = `DCSC_ERR_RANGE;
        end else begin
          do_trig = op_trig;
          do_imm = !op_trig;
        end
      end
      `DCSC_OP_CI_QRY, `DCSC_OP_CT_QRY, `DCSC_OP_VI_QRY, `DCSC_OP_VT_QRY: begin
        if (!ch_ok) begin
          next_err = `DCSC_ERR_CH;
        end else if (sel_cur != op_cur) begin
          next_err = `DCSC_ERR_MODE;
        end else begin
          res_load = 1'b1;
          if (kw != `DCSC_KW_VAL) begin
            next_result = kw_level;
          end else if ((op == `DCSC_OP_CT_QRY) || (op == `DCSC_OP_VT_QRY)) begin
            next_result = sel_last;
          end else begin
            next_result = sel_imm;
          end
        end
      end
      `DCSC_OP_MODE_SET: begin
        if (!ch_ok) begin
          next_err = `DCSC_ERR_CH;
        end else if (armed) begin
          next_err = `DCSC_ERR_ARMED;
        end else if (!sel_prog) begin
          next_err = `DCSC_ERR_JUMPER;
        end else begin
          do_mode = 1'b1;
        end
      end
      `DCSC_OP_MODE_QRY: begin
        if (!ch_ok) begin
          next_err = `DCSC_ERR_CH;
        end else begin
          res_load = 1'b1;
          next_result = sel_cur ? `DCSC_TXT_CURR : `DCSC_TXT_VOLT;
        end
      end
      `DCSC_OP_RELAY_SET: begin
        if (!ch_ok) begin
          next_err = `DCSC_ERR_CH;
        end else begin
          do_relay = 1'b1;
        end
      end
      `DCSC_OP_RELAY_QRY: begin
        if (!ch_ok) begin
          next_err = `DCSC_ERR_CH;
        end else begin
          res_load = 1'b1;
          next_result = {31'h00000000, sel_relay};
        end
      end
      `DCSC_OP_INIT: begin
        do_init = 1'b1;
      end
      `DCSC_OP_TRIG: begin
        do_swtrig = 1'b1;
      end
      default: begin
        next_err = `DCSC_ERR_OP;
      end
    endcase
  end
end

wire cmd_err = (next_err != `DCSC_ERR_NONE);
wire trig_any = trig_in || do_swtrig;
wire fire = armed && trig_any;
wire trig_ign = trig_any && !armed;

// software registers, error flag, arming, strap capture
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    value_reg <= `DCSC_LEVEL_RST;
    result <= `DCSC_LEVEL_RST;
    err_flag <= 1'b0;
    err_code <= `DCSC_ERR_NONE;
    armed <= 1'b0;
    init_done <= 1'b0;
  end else begin
    init_done <= 1'b1;
    if (wr_q && (addr_q == `DCSC_VALUE_OFS)) begin
      value_reg <= hwdata;
    end
    if (res_load) begin
      result <= next_result;
    end
    // a new error beats a write-one clear in the same cycle
    if (cmd_err) begin
      err_flag <= 1'b1;
      err_code <= next_err;
    end else if (wr_q && (addr_q == `DCSC_STATUS_OFS) && hwdata[`DCSC_ST_ERR_BIT]) begin
      err_flag <= 1'b0;
    end
    if (fire) begin
      armed <= 1'b0;
    end else if (do_init) begin
      armed <= 1'b1;
    end
  end
end

// channel array, padded to sixteen slots for the read muxes
genvar i;
generate
  for (i = 0; i < 16; i = i + 1) begin : g_ch
    localparam [31:0] CI_W = i;
    localparam [4:0] CI = CI_W[4:0];
    if (i < NUM_CH) begin : g_on
      assign prog16[i] = prog_sel_jumper[i];
      assign vi16[i] = vi_cur_jumper[i];
      assign ch_mode_cur[i] = mode16[i];
      assign relay_closed[i] = relay16[i];
      dcsc_chan u_chan (
        .clk(clk),
        .reset_n(reset_n),
        .load_strap(!init_done),
        .prog_sel(prog_sel_jumper[i]),
        .vi_cur(vi_cur_jumper[i]),
        .set_mode(do_mode && (ch == CI)),
        .mode_in(value_reg[0]),
        .set_imm(do_imm && (ch == CI)),
        .set_trig(do_trig && (ch == CI)),
        .level_in(level_arg),
        .fire(fire),
        .set_relay(do_relay && (ch == CI)),
        .relay_in(value_reg[0]),
        .mode_cur(mode16[i]),
        .imm_level(imm_bus[i*32 +: 32]),
        .last_level(last_bus[i*32 +: 32]),
        .relay(relay16[i]),
        .dac_level(dac_level[i*32 +: 32])
      );
    end else begin : g_off
      assign prog16[i] = 1'b0;
      assign vi16[i] = 1'b0;
      assign mode16[i] = 1'b0;
      assign relay16[i] = 1'b0;
      assign imm_bus[i*32 +: 32] = `DCSC_LEVEL_RST;
      assign last_bus[i*32 +: 32] = `DCSC_LEVEL_RST;
    end
  end
endgenerate

// event sources: questionable trigger-ignored, standard execution error
wire [15:0] ques_set = {16{trig_ign}} & (16'h0001 << `DCSC_QUES_TRIG_IGN_BIT);
wire [15:0] esr_set = {16{cmd_err}} & (16'h0001 << `DCSC_ESR_EXEC_BIT);
wire [47:0] ev_set = {esr_set, ques_set, 16'h0000};

genvar g;
generate
  for (g = 0; g < 3; g = g + 1) begin : g_grp
    localparam [31:0] GB_W = `DCSC_GRP_BASE + g;
    localparam [3:0] GB = GB_W[3:0];
    reg [15:0] ev;
    reg [15:0] en;
    wire clr = rd_go && (haddr[7:4] == GB) && (haddr[3:2] == `DCSC_SUB_EVENT);
    // read clears, but a set in the same cycle survives
    always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        ev <= 16'h0000;
        en <= 16'h0000;
      end else begin
        ev <= (clr ? 16'h0000 : ev) | ev_set[g*16 +: 16];
        if (wr_q && (addr_q[7:4] == GB) && (addr_q[3:2] == `DCSC_SUB_ENABLE)) begin
          en <= hwdata[15:0];
        end
      end
    end
    assign ev_all[g*16 +: 16] = ev;
    assign en_all[g*16 +: 16] = en;
    assign summ[g] = |(ev & en);
  end
endgenerate

// status word layout
always @* begin
  st_word = 32'h00000000;
  st_word[`DCSC_ST_ERR_BIT] = err_flag;
  st_word[`DCSC_ST_ARMED_BIT] = armed;
  st_word[`DCSC_ST_CODE_MSB:`DCSC_ST_CODE_LSB] = err_code;
  st_word[`DCSC_ST_SUM_MSB:`DCSC_ST_SUM_LSB] = summ;
end

// read mux on the address phase; conditions are all zero since only events exist
wire [3:0] gidx = haddr[7:4] - `DCSC_GRP_BASE;
always @* begin
  case (haddr[7:0])
    `DCSC_VALUE_OFS: rd_mux = value_reg;
    `DCSC_RESULT_OFS: rd_mux = result;
    `DCSC_STATUS_OFS: rd_mux = st_word;
    `DCSC_MODE_OFS: rd_mux = {relay16, mode16};
    `DCSC_JUMPER_OFS: rd_mux = {vi16, prog16};
    default: begin
      rd_mux = 32'h00000000;
      if ((gidx < `DCSC_GRP_COUNT) && (haddr[3:2] == `DCSC_SUB_EVENT)) begin
        rd_mux = {16'h0000, ev_all[gidx[1:0]*16 +: 16]};
      end else if ((gidx < `DCSC_GRP_COUNT) && (haddr[3:2] == `DCSC_SUB_ENABLE)) begin
        rd_mux = {16'h0000, en_all[gidx[1:0]*16 +: 16]};
      end
    end
  endcase
end

// read data registered so it stands through the data phase
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    hrdata <= 32'h00000000;
  end else if (rd_go) begin
    hrdata <= rd_mux;
  end
end

endmodule // dcsc_core
`default_nettype wire

// ==== dcsc_core_checker.sv ====
// checker for the channel source controller: watches the top ports only.
// assumes one clock, async active-low reset and static jumper inputs.
`timescale 1ns/1ns
`default_nettype none
`include "dcsc_map.vh"
module dcsc_core_checker #(
  parameter NUM_CH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [NUM_CH-1:0] prog_sel_jumper,
  input wire logic [NUM_CH-1:0] vi_cur_jumper,
  input wire logic trig_in,
  input wire logic [NUM_CH-1:0] ch_mode_cur,
  input wire logic [NUM_CH-1:0] relay_closed,
  input wire logic [NUM_CH*32-1:0] dac_level,
  input wire logic armed
);
  logic wdp_cmd;
  // high during the data phase of a command write
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wdp_cmd <= 1'b0;
    end else if (hready) begin
      wdp_cmd <= hsel && htrans[1] && hwrite && (haddr[7:0] == `DCSC_CMD_OFS);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  strap_mode_a: assert property ($rose(reset_n) |=>
    ch_mode_cur == (vi_cur_jumper & ~prog_sel_jumper) && relay_closed == '0)
    else $error("mode or relay wrong after reset");
  // excludes the capture edge, where jumper modes load
  strap_hold_a: assert property (!$rose(reset_n) |=>
    $stable(ch_mode_cur & ~prog_sel_jumper)) else $error("jumper channel mode moved");
  armed_mode_a: assert property (armed |-> $stable(ch_mode_cur))
    else $error("mode changed while armed");
  trig_apply_a: assert property (armed && trig_in |=> !armed)
    else $error("trigger did not disarm");
  arm_cause_a: assert property ($rose(armed) |->
    $past(wdp_cmd) && $past(hwdata[3:0]) == `DCSC_OP_INIT) else $error("armed without initiate");
  idle_trig_a: assert property (!armed && trig_in && !wdp_cmd |=> $stable(dac_level))
    else $error("unarmed trigger moved a level");
  mode_relay_a: assert property ($changed(ch_mode_cur) |->
    (relay_closed & (ch_mode_cur ^ $past(ch_mode_cur))) == '0) else $error("relay closed on mode change");
  genvar g;
  // an open relay keeps the terminal at zero
  for (g = 0; g < NUM_CH; g++) begin : g_ch
    open_zero_a: assert property (relay_closed[g] || dac_level[g*32 +: 32] == 32'h0)
      else $error("level present with relay open");
  end
endmodule // dcsc_core_checker
bind dcsc_core dcsc_core_checker #(.NUM_CH(NUM_CH)) dcsc_core_checker_inst (.*);
`default_nettype wire

// ==== dcsc_host_model.sv ====
// host side: an AHB-Lite master doing single whole-word transfers.
// assumes the slave ready feeds hready; read data reported one cycle.
`timescale 1ns/1ns
`default_nettype none
module dcsc_host_model (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic rd_valid,
  output logic [31:0] rd_data
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  logic dp_rd = 1'b0;
  // address phase, then data phase, each held until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hwdata <= ~d; // stale data never looks valid
  endtask
  // read data taken at the edge ending a read data phase, reported for one cycle
  always @(posedge clk) begin
    rd_valid <= dp_rd && hready;
    rd_data <= hrdata;
    if (hready) dp_rd <= hsel && htrans[1] && !hwrite;
  end
endmodule // dcsc_host_model
`default_nettype wire

// ==== dcsc_core_tb_top.sv ====
// self-checking bench for the channel source controller.
// assumes the host model drives the bus; reads checked in order.
`timescale 1ns/1ns
`default_nettype none
`include "dcsc_map.vh"
module dcsc_core_tb_top;
  typedef struct {logic [7:0] a; logic [31:0] v; logic [31:0] m;} dcsc_exp_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic trig_in = 1'b0;
  logic [7:0] prog_sel_jumper = 8'hFB;
  logic [7:0] vi_cur_jumper = 8'h04;
  wire hsel, hwrite, hreadyout, hresp, armed, rd_valid;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] haddr, hwdata, hrdata, rd_data;
  wire [7:0] ch_mode_cur, relay_closed;
  wire [255:0] dac_level;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  dcsc_exp_t q[$];
  dcsc_exp_t ex;
  logic [31:0] v, w, c;
  logic [31:0] vlim [4] = '{32'h0, `DCSC_V_MIN, `DCSC_V_MAX, 32'h0};
  logic [31:0] ilim [4] = '{32'h0, `DCSC_I_MIN, `DCSC_I_MAX, 32'h0};
  logic [4:0] bad [3] = '{5'd0, 5'd9, 5'd31};
  dcsc_core #(.NUM_CH(8)) dcsc_core_inst (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .prog_sel_jumper(prog_sel_jumper), .vi_cur_jumper(vi_cur_jumper), .trig_in(trig_in),
    .ch_mode_cur(ch_mode_cur), .relay_closed(relay_closed), .dac_level(dac_level), .armed(armed));
  dcsc_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .rd_valid(rd_valid), .rd_data(rd_data));
  initial forever #25 clk = ~clk;
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{a, e, m});
    host.xfer(1'b0, a, 32'h0);
  endtask
  // argument first, then the command word
  task automatic cmd(input logic [3:0] op, input logic [4:0] ch, input logic [1:0] kw, input logic [31:0] d);
    host.xfer(1'b1, `DCSC_VALUE_OFS, d);
    host.xfer(1'b1, `DCSC_CMD_OFS, {14'h0, kw, 3'h0, ch, 4'h0, op});
  endtask
  task automatic qry(input logic [3:0] op, input logic [4:0] ch, input logic [1:0] kw, input logic [31:0] e);
    cmd(op, ch, kw, 32'h0);
    rd(`DCSC_RESULT_OFS, e, 32'hFFFFFFFF);
  endtask
  // error code and flag, then clear the flag
  task automatic chk_err(input logic [3:0] e);
    rd(`DCSC_STATUS_OFS, {24'h0, e, 3'h0, e != 4'h0}, 32'hF1);
    host.xfer(1'b1, `DCSC_STATUS_OFS, 32'h1);
  endtask
  task automatic odac(input int k, input logic [31:0] e);
    @(negedge clk);
    chk("dac_level", e, dac_level[32*k +: 32]);
  endtask
  task automatic pulse();
    @(posedge clk);
    trig_in <= 1'b1;
    @(posedge clk);
    trig_in <= 1'b0;
  endtask
  task automatic boot();
    repeat (2) @(posedge clk);
    rd(`DCSC_MODE_OFS, 32'h4, 32'hFFFFFFFF);
    rd(`DCSC_JUMPER_OFS, {8'h0, vi_cur_jumper, 8'h0, prog_sel_jumper}, 32'hFFFFFFFF);
    qry(`DCSC_OP_VI_QRY, 5'd1, 2'h0, 32'h0);
  endtask
  // reads are compared in the order they were issued
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      ex = q.pop_front();
      chk($sformatf("read %h", ex.a), ex.v & ex.m, rd_data & ex.m);
    end
  end
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    v = $urandom(32'h624b01a1);
    vi_cur_jumper <= 8'($urandom) | 8'h04;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    boot();
    qry(`DCSC_OP_MODE_QRY, 5'd1, 2'h0, `DCSC_TXT_VOLT);
    qry(`DCSC_OP_MODE_QRY, 5'd3, 2'h0, `DCSC_TXT_CURR);
    for (int i = 0; i < 3; i++) begin
      cmd(`DCSC_OP_MODE_QRY, bad[i], 2'h0, 32'h0);
      chk_err(`DCSC_ERR_CH);
    end
    qry(`DCSC_OP_MODE_QRY, 5'd8, 2'h0, `DCSC_TXT_VOLT);
    // flag stays clear, code still shows the last error
    rd(`DCSC_STATUS_OFS, {24'h0, `DCSC_ERR_CH, 4'h0}, 32'hF1);
    v = $urandom;
    v[30:23] = 8'h80 + 8'($urandom % 3);
    cmd(`DCSC_OP_VI_SET, 5'd1, 2'h0, v);
    odac(0, 32'h0);
    cmd(`DCSC_OP_RELAY_SET, 5'd1, 2'h0, 32'h1);
    odac(0, v);
    qry(`DCSC_OP_VI_QRY, 5'd1, 2'h0, v);
    for (int k = 1; k < 4; k++) begin
      qry(`DCSC_OP_VI_QRY, 5'd1, k[1:0], vlim[k]);
      cmd(`DCSC_OP_VI_SET, 5'd2, k[1:0], 32'h0);
      qry(`DCSC_OP_VI_QRY, 5'd2, 2'h0, vlim[k]);
    end
    cmd(`DCSC_OP_VI_SET, 5'd1, 2'h0, 32'h41880000);
    chk_err(`DCSC_ERR_RANGE);
    qry(`DCSC_OP_VI_QRY, 5'd1, 2'h0, v);
    cmd(`DCSC_OP_CI_SET, 5'd1, 2'h0, 32'h0);
    chk_err(`DCSC_ERR_MODE);
    cmd(`DCSC_OP_VI_QRY, 5'd3, 2'h0, 32'h0);
    chk_err(`DCSC_ERR_MODE);
    cmd(`DCSC_OP_MODE_SET, 5'd3, 2'h0, 32'h0);
    chk_err(`DCSC_ERR_JUMPER);
    w = $urandom;
    w[30:23] = 8'h7F;
    cmd(`DCSC_OP_VT_SET, 5'd1, 2'h0, w);
    qry(`DCSC_OP_VT_QRY, 5'd1, 2'h0, w);
    qry(`DCSC_OP_VI_QRY, 5'd1, 2'h0, v);
    odac(0, v);
    cmd(`DCSC_OP_INIT, 5'd1, 2'h0, 32'h0);
    cmd(`DCSC_OP_VT_SET, 5'd1, 2'h0, 32'h0);
    chk_err(`DCSC_ERR_ARMED);
    cmd(`DCSC_OP_MODE_SET, 5'd1, 2'h0, 32'h1);
    chk_err(`DCSC_ERR_ARMED);
    rd(`DCSC_STATUS_OFS, 32'h2, 32'h2);
    pulse();
    odac(0, w);
    rd(`DCSC_STATUS_OFS, 32'h0, 32'h2);
    qry(`DCSC_OP_RELAY_QRY, 5'd1, 2'h0, 32'h1);
    cmd(`DCSC_OP_MODE_SET, 5'd1, 2'h0, 32'h1);
    rd(`DCSC_MODE_OFS, 32'h5, 32'hFFFFFFFF);
    odac(0, 32'h0);
    qry(`DCSC_OP_RELAY_QRY, 5'd1, 2'h0, 32'h0);
    qry(`DCSC_OP_CI_QRY, 5'd1, 2'h0, 32'h0);
    qry(`DCSC_OP_MODE_QRY, 5'd1, 2'h0, `DCSC_TXT_CURR);
    c = $urandom;
    c[30:23] = 8'h78;
    cmd(`DCSC_OP_CI_SET, 5'd1, 2'h0, c);
    cmd(`DCSC_OP_CT_SET, 5'd1, 2'h0, c ^ 32'h80000000);
    qry(`DCSC_OP_CT_QRY, 5'd1, 2'h0, c ^ 32'h80000000);
    qry(`DCSC_OP_CI_QRY, 5'd1, 2'h0, c);
    cmd(`DCSC_OP_CI_SET, 5'd1, 2'h0, 32'h3D000000);
    chk_err(`DCSC_ERR_RANGE);
    cmd(`DCSC_OP_CI_SET, 5'd1, `DCSC_KW_DEF, c);
    qry(`DCSC_OP_CI_QRY, 5'd1, 2'h0, 32'h0);
    for (int k = 1; k < 4; k++) begin
      qry(`DCSC_OP_CI_QRY, 5'd1, k[1:0], ilim[k]);
    end
    // back to voltage, then a software trigger and an unknown opcode
    cmd(`DCSC_OP_MODE_SET, 5'd1, 2'h0, 32'h0);
    qry(`DCSC_OP_MODE_QRY, 5'd1, 2'h0, `DCSC_TXT_VOLT);
    cmd(`DCSC_OP_INIT, 5'd1, 2'h0, 32'h0);
    cmd(`DCSC_OP_TRIG, 5'd1, 2'h0, 32'h0);
    rd(`DCSC_STATUS_OFS, 32'h0, 32'h2);
    cmd(4'hF, 5'd1, 2'h0, 32'h0);
    chk_err(`DCSC_ERR_OP);
    host.xfer(1'b1, 8'h38, 32'h0200);
    rd(8'h38, 32'h200, 32'hFFFF);
    pulse();
    rd(`DCSC_STATUS_OFS, 32'h200, 32'h200);
    rd(8'h34, 32'h200, 32'hFFFF);
    rd(8'h34, 32'h0, 32'hFFFF);
    rd(8'h44, 32'h10, 32'h10);
    rd(8'h30, 32'h0, 32'hFFFFFFFF);
    rd(8'h7C, 32'h0, 32'hFFFFFFFF);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    boot();
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule // dcsc_core_tb_top
`default_nettype wire
